/* hdl/cps_pkg.sv */
// Constants, register map and state codes of the converter protection sequencer
package cps_pkg;
    // Clock rate
    localparam int CLK_MHZ          = 10;
    localparam int CNT_W            = 24;
    localparam int LVL_W            = 8;
    // Timed intervals, printed in microseconds
    localparam int FAULT_TIME_US    = 100000;
    localparam int AUTOREC_TIME_US  = 1000000;
    localparam int SSTART_TIME_US   = 5000;
    localparam int SSKIP_TIME_US    = 300;
    localparam int OVP_BLANK_US     = 10;
    localparam int OTP_BLANK_US     = 10;
    // Derived cycle counts (least times, never below one cycle)
    localparam int FAULT_CYC        = FAULT_TIME_US * CLK_MHZ;
    localparam int AUTOREC_CYC      = AUTOREC_TIME_US * CLK_MHZ;
    localparam int SSTART_CYC       = SSTART_TIME_US * CLK_MHZ;
    localparam int SSKIP_CYC        = SSKIP_TIME_US * CLK_MHZ;
    localparam int OVP_BLANK_CYC    = (OVP_BLANK_US * CLK_MHZ < 1) ? 1 : OVP_BLANK_US * CLK_MHZ;
    localparam int OTP_BLANK_CYC    = (OTP_BLANK_US * CLK_MHZ < 1) ? 1 : OTP_BLANK_US * CLK_MHZ;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] LEVEL_OFS  = 8'h08;
    localparam logic [7:0] EVENT_OFS  = 8'h0C;
    // Control fields and reset value
    localparam int CTRL_SWOFF_BIT       = 0;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    // Status fields
    localparam int ST_STATE_LSB     = 0;
    localparam int ST_TIMER_BIT     = 3;
    localparam int ST_LATCH_BIT     = 4;
    localparam int ST_FOLD_BIT      = 5;
    localparam int ST_DRIVE_BIT     = 6;
    // Sticky event fields
    localparam int EV_FAULT_BIT     = 0;
    localparam int EV_OVP_BIT       = 1;
    localparam int EV_OTP_BIT       = 2;
    localparam int EV_TSD_BIT       = 3;
    localparam int EV_W             = 4;
    localparam logic [EV_W-1:0] EV_RESET = 4'h0;
    // Sequencer states
    typedef enum logic [2:0] {
        CPS_OFF     = 3'b000,
        CPS_START   = 3'b001,
        CPS_RUN     = 3'b010,
        CPS_SKIP    = 3'b011,
        CPS_SSKIP   = 3'b100,
        CPS_AUTOREC = 3'b101,
        CPS_LATCHED = 3'b110,
        CPS_TSD     = 3'b111
    } cps_state_t;
endpackage

/* hdl/cps_sequencer.sv */
// Protection and low-load sequencer with APB status and control registers
`timescale 1ns/1ps
// Contract
// - Peak current limit reached starts the fault timer.
// - Timer expiry stops drive, then latches off or autorecovers per build option.
// - Limit released before expiry clears the fault timer.
// - A pulse ended by maximum duty also starts the fault timer.
// - Autorecovery waits the restart delay, then restarts; persisting fault repeats.
// - Latched-off state clears only on line undervoltage, supply reset or thermal shutdown.
// - Supply low while the timer runs enters protection at once.
// - Feedback below foldback threshold folds the frequency toward its minimum.
// - During foldback regulation continues but jittering is off.
// - Foldback is inhibited while running at maximum duty.
// - Feedback at skip-entry stops drive; skip holds below skip-exit threshold.
// - Skip exit restarts drive with a short voltage-mode ramp from zero.
// - Feedback above foldback during that ramp ends it at once.
// - Switching only inside the latch-pin window; crossing either edge latches off.
// - Latch-pin crossings shorter than their filter time are ignored.
// - Latch-pin latch-off clears only on line undervoltage, supply reset or thermal shutdown.
// - Latch pin ignored until ready; high latch armed at turn-on, gates start.
// - Low latch-pin threshold acted on only after the startup ramp.
// - Thermistor bias doubled during the startup ramp.
// - Thermal shutdown stops switching, disables startup source, resets logic.
// - Thermal shutdown release re-enables the source and starts normally.
// - Each start ramps the current setpoint from zero to the limit.
module cps_sequencer #(
    parameter bit LATCHED_OPTION = 1'b0,
    parameter int FAULT_CYC      = cps_pkg::FAULT_CYC,
    parameter int AUTOREC_CYC    = cps_pkg::AUTOREC_CYC,
    parameter int SSTART_CYC     = cps_pkg::SSTART_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Comparator flags
    input  wire logic        pwm_request,
    input  wire logic        peak_current_limit,
    input  wire logic        cs_trip_end,
    input  wire logic        max_duty_end,
    input  wire logic        supply_low_level,
    input  wire logic        supply_turn_on_level,
    input  wire logic        supply_reset_level,
    input  wire logic        line_undervoltage,
    input  wire logic        fb_below_fold,
    input  wire logic        fb_below_skip_in,
    input  wire logic        fb_above_skip_out,
    input  wire logic        latch_pin_high,
    input  wire logic        latch_pin_low,
    input  wire logic        thermal_shutdown_flag,
    // Controls toward the analog side
    output logic             gate_drive_output,
    output logic             hv_source_enable,
    output logic             ntc_bias_double,
    output logic             foldback_enable,
    output logic             jitter_enable,
    output logic             skip_low_power,
    output logic             ramp_voltage_mode,
    output logic [7:0]       setpoint_level
);
    import cps_pkg::*;

    localparam int SS_STEP  = (SSTART_CYC / 255 < 1) ? 1 : SSTART_CYC / 255;
    localparam int SK_STEP  = (SSKIP_CYC / 255 < 1) ? 1 : SSKIP_CYC / 255;

    cps_state_t             state_reg;
    cps_state_t             state_next;
    logic [CNT_W-1:0]       fault_cnt_reg;
    logic                   fault_run_reg;
    logic                   maxduty_reg;
    logic [CNT_W-1:0]       wait_cnt_reg;
    logic [CNT_W-1:0]       step_cnt_reg;
    logic [LVL_W-1:0]       level_reg;
    logic [CNT_W-1:0]       ovp_cnt_reg;
    logic [CNT_W-1:0]       otp_cnt_reg;
    logic                   latch_off_reg;
    logic [31:0]            ctrl_reg;
    logic [EV_W-1:0]        event_reg;
    logic                   fault_expired;
    logic                   protect_req;
    logic                   ovp_fire;
    logic                   otp_fire;
    logic                   armed_high;
    logic                   armed_low;
    logic                   ramping;
    logic                   ramp_done;
    logic                   bus_write;
    logic                   bus_read;

    // Fixed map decode, shared by read and write paths
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == LEVEL_OFS)
              || (a == EVENT_OFS);
    endfunction

    // True for the states in which the power stage is driven
    function automatic logic drives(input cps_state_t s);
        drives = (s == CPS_START) || (s == CPS_RUN) || (s == CPS_SSKIP);
    endfunction

    assign fault_expired = fault_run_reg && (fault_cnt_reg >= CNT_W'(FAULT_CYC - 1));
    // Supply dropping while the timer runs counts as an expired fault
    assign protect_req   = fault_expired || (fault_run_reg && supply_low_level);
    assign armed_high    = drives(state_reg) || (state_reg == CPS_SKIP)
                         || (state_reg == CPS_OFF && supply_turn_on_level);
    assign armed_low     = (state_reg == CPS_RUN) || (state_reg == CPS_SKIP)
                         || (state_reg == CPS_SSKIP);
    assign ovp_fire      = armed_high && latch_pin_high
                         && (ovp_cnt_reg >= CNT_W'(OVP_BLANK_CYC - 1));
    assign otp_fire      = armed_low && latch_pin_low
                         && (otp_cnt_reg >= CNT_W'(OTP_BLANK_CYC - 1));
    assign ramping       = (state_reg == CPS_START) || (state_reg == CPS_SSKIP);
    assign ramp_done     = (level_reg == 8'hFF);
    assign bus_read      = psel && penable && !pready && !pwrite;
    assign bus_write     = psel && penable && pready && pwrite;

    // Next state; thermal shutdown outranks everything, supply reset everything but thermal shutdown
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CPS_OFF: begin
                // Start only with the high latch clear
                if (supply_turn_on_level && !line_undervoltage && !latch_off_reg
                    && !ovp_fire) begin
                    state_next = CPS_START;
                end
            end
            CPS_START: begin
                if (ramp_done) begin
                    state_next = CPS_RUN;
                end
            end
            CPS_RUN: begin
                if (fb_below_skip_in) begin
                    state_next = CPS_SKIP;
                end
            end
            CPS_SKIP: begin
                if (fb_above_skip_out) begin
                    state_next = CPS_SSKIP;
                end
            end
            CPS_SSKIP: begin
                // Load transient aborts the soft restart at once
                if (!fb_below_fold || ramp_done) begin
                    state_next = CPS_RUN;
                end
            end
            CPS_AUTOREC: begin
                if (wait_cnt_reg >= CNT_W'(AUTOREC_CYC - 1)) begin
                    state_next = CPS_OFF;
                end
            end
            CPS_LATCHED: begin
                if (line_undervoltage) begin
                    state_next = CPS_OFF;
                end
            end
            CPS_TSD: begin
                if (!thermal_shutdown_flag) begin
                    state_next = CPS_OFF;
                end
            end
            default: state_next = CPS_OFF;
        endcase
        // Protection paths from any driving or skipping state
        if (drives(state_reg) || state_reg == CPS_SKIP) begin
            if (ovp_fire || otp_fire) begin
                state_next = CPS_LATCHED;
            end else if (protect_req) begin
                state_next = LATCHED_OPTION ? CPS_LATCHED : CPS_AUTOREC;
            end else if (line_undervoltage) begin
                state_next = CPS_OFF;
            end
        end
        if (thermal_shutdown_flag) begin
            state_next = CPS_TSD;
        end
    end

    // State register; supply reset behaves as a logic reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= CPS_OFF;
        end else if (supply_reset_level && !thermal_shutdown_flag) begin
            state_reg <= CPS_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Fault timer: started by limit or max-duty end, cleared by normal ending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_run_reg <= 1'b0;
            fault_cnt_reg <= '0;
            maxduty_reg   <= 1'b0;
        end else if (!drives(state_reg) || thermal_shutdown_flag) begin
            fault_run_reg <= 1'b0;
            fault_cnt_reg <= '0;
            maxduty_reg   <= 1'b0;
        end else begin
            if (max_duty_end) begin
                maxduty_reg <= 1'b1;
            end else if (cs_trip_end) begin
                maxduty_reg <= 1'b0;
            end
            if (peak_current_limit || max_duty_end) begin
                fault_run_reg <= 1'b1;
                if (fault_run_reg && !fault_expired) begin
                    fault_cnt_reg <= fault_cnt_reg + 1'b1;
                end
            end else if (!maxduty_reg) begin
                fault_run_reg <= 1'b0;
                fault_cnt_reg <= '0;
            end else if (!fault_expired) begin
                fault_cnt_reg <= fault_cnt_reg + 1'b1;
            end
        end
    end

    // Restart delay counter for autorecovery
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt_reg <= '0;
        end else if (state_reg == CPS_AUTOREC) begin
            wait_cnt_reg <= wait_cnt_reg + 1'b1;
        end else begin
            wait_cnt_reg <= '0;
        end
    end

    // Setpoint ramp shared by startup and skip-exit restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_reg <= '0;
            level_reg    <= '0;
        end else if (!ramping || state_next != state_reg) begin
            step_cnt_reg <= '0;
            level_reg    <= '0;
        end else if (step_cnt_reg >= CNT_W'((state_reg == CPS_START ? SS_STEP : SK_STEP) - 1))
        begin
            step_cnt_reg <= '0;
            level_reg    <= ramp_done ? level_reg : level_reg + 1'b1;
        end else begin
            step_cnt_reg <= step_cnt_reg + 1'b1;
        end
    end

    // Latch-pin blanking filters; a short spike restarts the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovp_cnt_reg <= '0;
            otp_cnt_reg <= '0;
        end else begin
            ovp_cnt_reg <= (armed_high && latch_pin_high && !ovp_fire)
                         ? ovp_cnt_reg + 1'b1 : (ovp_fire ? ovp_cnt_reg : '0);
            otp_cnt_reg <= (armed_low && latch_pin_low && !otp_fire)
                         ? otp_cnt_reg + 1'b1 : (otp_fire ? otp_cnt_reg : '0);
        end
    end

    // Latch-off memory; only undervoltage, supply reset or thermal shutdown clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_off_reg <= 1'b0;
        end else if (thermal_shutdown_flag) begin
            latch_off_reg <= 1'b0;
        end else if (ovp_fire || otp_fire) begin
            latch_off_reg <= 1'b1;
        end else if (line_undervoltage || supply_reset_level) begin
            latch_off_reg <= 1'b0;
        end
    end

    // Analog-side controls, registered so that glitches never reach the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_drive_output <= 1'b0;
            hv_source_enable  <= 1'b1;
            ntc_bias_double   <= 1'b0;
            foldback_enable   <= 1'b0;
            jitter_enable     <= 1'b0;
            skip_low_power    <= 1'b0;
            ramp_voltage_mode <= 1'b0;
            setpoint_level    <= '0;
        end else begin
            gate_drive_output <= pwm_request && drives(state_next)
                               && !ctrl_reg[CTRL_SWOFF_BIT];
            hv_source_enable  <= !thermal_shutdown_flag;
            ntc_bias_double   <= (state_next == CPS_START);
            foldback_enable   <= (state_next == CPS_RUN) && fb_below_fold
                               && !maxduty_reg;
            jitter_enable     <= drives(state_next)
                               && !(fb_below_fold && !maxduty_reg);
            skip_low_power    <= (state_next == CPS_SKIP);
            ramp_voltage_mode <= (state_next == CPS_SSKIP);
            setpoint_level    <= ramping ? level_reg : 8'hFF;
        end
    end

    // Control register, written on the completing access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (bus_write && paddr == CTRL_OFS) begin
            ctrl_reg <= {31'h0000_0000, pwdata[CTRL_SWOFF_BIT]};
        end
    end

    // Sticky events; a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_reg <= EV_RESET;
        end else begin
            event_reg <= (event_reg & ~((bus_write && paddr == EVENT_OFS)
                                        ? pwdata[EV_W-1:0] : EV_RESET))
                       | {thermal_shutdown_flag, otp_fire, ovp_fire, protect_req};
        end
    end

    // APB answer: one wait state, error on unmapped addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= !mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (bus_read) begin
                case (paddr)
                    CTRL_OFS:   prdata <= ctrl_reg;
                    STATUS_OFS: prdata <= {25'h000_0000, gate_drive_output, foldback_enable,
                                           latch_off_reg, fault_run_reg, state_reg};
                    LEVEL_OFS:  prdata <= {24'h00_0000, setpoint_level};
                    EVENT_OFS:  prdata <= {28'h000_0000, event_reg};
                    default:    prdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Checks on the sequencing
    default clocking cps_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence limit_held_s;
        peak_current_limit && drives(state_reg) && !thermal_shutdown_flag;
    endsequence

    timer_start_a: assert property ((limit_held_s ##1 limit_held_s)
        |-> fault_run_reg)
        else $error("fault timer not running under current limit");
    timer_expire_a: assert property ((fault_expired && !thermal_shutdown_flag
        && !supply_reset_level && !ovp_fire && !otp_fire)
        |=> (state_reg == (LATCHED_OPTION ? CPS_LATCHED : CPS_AUTOREC)))
        else $error("expired fault timer did not enter protection");
    timer_clear_a: assert property ((drives(state_reg) && !peak_current_limit
        && !max_duty_end && !maxduty_reg && !thermal_shutdown_flag) |=> !fault_run_reg)
        else $error("fault timer not cleared");
    maxduty_start_a: assert property ((max_duty_end && drives(state_reg)
        && !thermal_shutdown_flag) |=> fault_run_reg)
        else $error("max duty end did not start timer");
    supply_low_a: assert property ((fault_run_reg && supply_low_level && drives(state_reg)
        && !thermal_shutdown_flag && !supply_reset_level) |=> !drives(state_reg))
        else $error("supply low did not stop switching");
    latched_hold_a: assert property ((state_reg == CPS_LATCHED && !line_undervoltage
        && !supply_reset_level && !thermal_shutdown_flag) |=> state_reg == CPS_LATCHED)
        else $error("latched state left without cause");
    skip_stop_a: assert property ((state_reg == CPS_SKIP)
        |-> (!gate_drive_output && skip_low_power))
        else $error("drive active in skip");
    transient_a: assert property ((state_reg == CPS_SSKIP && !fb_below_fold
        && !thermal_shutdown_flag && !supply_reset_level && !protect_req
        && !ovp_fire && !otp_fire && !line_undervoltage) |=> state_reg == CPS_RUN)
        else $error("soft restart not ended by transient");
    fold_maxd_a: assert property (maxduty_reg |=> !foldback_enable)
        else $error("foldback during max duty");
    jitter_off_a: assert property (foldback_enable |-> !jitter_enable)
        else $error("jitter on during foldback");
    otp_wait_a: assert property ((state_reg == CPS_START) |-> !otp_fire)
        else $error("low latch acted on during startup ramp");
    spike_blank_a: assert property ((armed_high && latch_pin_high && !$past(latch_pin_high))
        |-> !ovp_fire)
        else $error("latch spike not blanked");
    ntc_boost_a: assert property ((state_reg == CPS_START && !thermal_shutdown_flag
        && !ramp_done && !supply_reset_level && !ovp_fire && !protect_req
        && !line_undervoltage) |=> ntc_bias_double)
        else $error("bias not doubled in startup ramp");
    tsd_stop_a: assert property (thermal_shutdown_flag |=> (!gate_drive_output
        && !hv_source_enable && state_reg == CPS_TSD))
        else $error("thermal shutdown did not stop");
    tsd_release_a: assert property ((state_reg == CPS_TSD && !thermal_shutdown_flag)
        |=> hv_source_enable)
        else $error("startup source not re-enabled");
    ramp_zero_a: assert property ((state_reg == CPS_OFF ##1 state_reg == CPS_START)
        |-> level_reg == 8'h00)
        else $error("startup ramp not from zero");
endmodule

/* testbench/cps_power_stage.sv */
// Behavioural power stage: oscillator request and current trip
`timescale 1ns/1ps
module cps_power_stage (
    // Clock
    input  wire logic pclk,
    // Gate and load in, request and pulse ends out
    input  wire logic gate_drive_output,
    input  wire logic heavy,
    output logic      pwm_request = 1'b0,
    output logic      cs_trip_end = 1'b0,
    output logic      max_duty_end = 1'b0
);
    logic [3:0] phase = 4'h0;
    // Ten-cycle period; under heavy load the current never trips, so max duty ends it
    always_ff @(posedge pclk) begin
        phase       <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
        pwm_request <= phase < 4'h8;
        cs_trip_end <= gate_drive_output && !heavy && phase == 4'h6;
        max_duty_end <= gate_drive_output && heavy && phase == 4'h7;
    end
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the protection sequencer
`timescale 1ns/1ps
module testbench;
    import cps_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0]  paddr = 8'h00, flags = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, pwm_request, cs_trip_end, gate_drive_output, max_duty_end;
    logic        hv_source_enable, supply_low_level = 0, supply_reset_level = 0;
    logic        ntc, fold, jit, skp, vm, heavy = 0, lo = 0;
    logic [7:0]  lvl;
    int          errors = 0, check_count = 0, n;
    // Rows: {thermal, latch high, line uv, turn-on, skip in, skip out, fold, limit}, state
    logic [10:0] rows [11] = '{11'h0A2, 11'h0D3, 11'h0B4, 11'h0A2, 11'h0AD, 11'h0A2,
                               11'h2A6, 11'h1A0, 11'h0A2, 11'h4A7, 11'h0A2};
    cps_sequencer #(.LATCHED_OPTION(1'b0), .FAULT_CYC(50), .AUTOREC_CYC(40), .SSTART_CYC(300))
    uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_request(pwm_request), .peak_current_limit(flags[0]), .cs_trip_end(cs_trip_end),
        .max_duty_end(max_duty_end), .supply_low_level(supply_low_level),
        .supply_turn_on_level(flags[4]), .supply_reset_level(supply_reset_level),
        .line_undervoltage(flags[5]), .fb_below_fold(flags[1]), .fb_below_skip_in(flags[3]),
        .fb_above_skip_out(flags[2]), .latch_pin_high(flags[6]), .latch_pin_low(lo),
        .thermal_shutdown_flag(flags[7]), .gate_drive_output(gate_drive_output),
        .hv_source_enable(hv_source_enable), .ntc_bias_double(ntc), .foldback_enable(fold),
        .jitter_enable(jit), .skip_low_power(skp), .ramp_voltage_mode(vm),
        .setpoint_level(lvl));
    cps_power_stage stage (.pclk(pclk), .gate_drive_output(gate_drive_output),
        .heavy(heavy), .pwm_request(pwm_request), .cs_trip_end(cs_trip_end),
        .max_duty_end(max_duty_end));
    // Clock and hang guard
    initial forever #50 pclk = ~pclk;
    initial begin
        #9_000_000;
        errors++;
        complete_run();
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer, held until pready; a spare edge keeps drivers apart
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            errors++;
            complete_run();
        end else begin
            q = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // Poll the state field under a bound
    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 300; i++) begin
            apb(1'b0, STATUS_OFS, 32'h0);
            if (q[2:0] === s) break;
        end
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        chk("hv_in_reset", hv_source_enable, 1'b1);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            flags <= rows[i][10:3];
            wait_st(rows[i][2:0]);
            chk("state", q[2:0], rows[i][2:0]);
            chk("skip_power", skp, rows[i][2:0] == 3'd3);
            chk("ramp_mode", vm, rows[i][2:0] == 3'd4);
            chk("hv_source", hv_source_enable, rows[i][2:0] != 3'd7);
        end
        // Short overload then short latch spike; both must be forgotten
        flags <= 8'h15;
        repeat (30) @(posedge pclk);
        flags <= 8'h54;
        repeat (60) @(posedge pclk);
        flags <= 8'h14;
        repeat (80) @(posedge pclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("short_faults", q[3:0], 4'h2);
        // Sticky events, clear by write-one, unmapped access
        apb(1'b0, EVENT_OFS, 32'h0);
        chk("events", q, 32'h0000_000B);
        apb(1'b1, EVENT_OFS, 32'h0000_000F);
        apb(1'b0, EVENT_OFS, 32'h0);
        chk("events_clear", q, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", {err, q[30:0]}, 32'h8000_0000);
        // Software drive-off must silence the gate, release must not
        apb(1'b1, CTRL_OFS, 32'h1);
        n = 0;
        repeat (40) @(posedge pclk) n += gate_drive_output;
        chk("drive_off", n, 0);
        apb(1'b1, CTRL_OFS, 32'h0);
        repeat (40) @(posedge pclk) n += gate_drive_output;
        chk("drive_on", n > 0, 1);
        // Max-duty pulses start the timer and hold foldback off
        flags <= 8'h16;
        heavy <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("fold_at_max_duty", fold, 1'b0);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("max_duty_timer", q[3], 1'b1);
        wait_st(3'd5);
        chk("max_duty_trip", q[2:0], 3'd5);
        heavy <= 1'b0;
        wait_st(3'd2);
        repeat (12) @(posedge pclk);
        chk("foldback", {fold, jit}, 2'b10);
        // Supply low while the timer runs protects well before expiry
        flags <= 8'h15;
        repeat (10) @(posedge pclk);
        supply_low_level <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("supply_low", q[2:0], 3'd5);
        supply_low_level <= 1'b0;
        flags <= 8'h14;
        wait_st(3'd2);
        // Supply reset clears a latch-off; low latch waits out the startup ramp
        flags <= 8'h54;
        wait_st(3'd6);
        flags <= 8'h14;
        supply_reset_level <= 1'b1;
        repeat (2) @(posedge pclk);
        supply_reset_level <= 1'b0;
        lo <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("ntc_boost", {ntc, lvl < 8'h04}, 2'b11);
        repeat (200) @(posedge pclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("low_latch_wait", q[2:0], 3'd1);
        wait_st(3'd6);
        chk("low_latch", q[4:0], 5'h16);
        lo <= 1'b0;
        flags <= 8'h34;
        wait_st(3'd0);
        flags <= 8'h14;
        wait_st(3'd2);
        chk("restart", q[2:0], 3'd2);
        complete_run();
    end
endmodule
